// file: design/fscr_top.sv
// System configuration register with APB access and the burst read sequencer it steers.
// Assumes an APB4 master on pclk; array data and correction logic live outside.
`default_nettype none

module fscr_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [fscr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  input  wire logic                       burst_start,
  input  wire logic                       burst_wrap,
  input  wire logic [4:0]                 burst_col,
  input  wire logic                       burst_stop,
  output logic                            data_valid,
  output logic [4:0]                      word_addr,
  output logic                            burst_busy,
  output logic                            sync_read,
  output logic                            ecc_correct_en,
  input  wire logic                       irq_ready,
  output logic                            rdy_o,
  output logic                            rdy_oe,
  output logic                            irq_o,
  output logic                            irq_oe
);

  fscr_pkg::fscr_cfg_t   cfg_r;
  fscr_pkg::fscr_cfg_t   cfg_nxt;
  fscr_pkg::fscr_state_t state_r;
  fscr_pkg::fscr_state_t state_nxt;
  logic [31:0]           prdata_r;
  logic [2:0]            lat_cnt_r;
  logic [4:0]            word_cnt_r;
  logic [4:0]            waddr_r;
  logic [4:0]            waddr_nxt;
  logic [4:0]            mask_r;
  logic                  wrap_r;
  logic                  bounded_r;
  logic                  hit;
  logic                  setup;
  logic                  wr_done;
  logic                  start_ok;
  logic                  last_word;
  logic                  valid_nxt;
  logic                  ready_level;
  logic [15:0]           wr_word;

  // APB slave, zero wait states
  assign hit     = (paddr == fscr_pkg::CFG_ADDR);
  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata_r <= hit ? {16'h0000, fscr_pkg::to_word(cfg_r)} : 32'h0000_0000;
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit register
  always_comb begin
    wr_word = fscr_pkg::to_word(cfg_r);
    if (pstrb[0]) begin
      wr_word[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      wr_word[15:8] = pwdata[15:8];
    end
  end

  always_comb begin
    cfg_nxt = fscr_pkg::from_word(wr_word);
    // Unsupported latency codes leave the field unchanged
    if (cfg_nxt.lat < fscr_pkg::LAT_MIN) begin
      cfg_nxt.lat = cfg_r.lat;
    end
    // Reserved length codes leave the field unchanged
    if (cfg_nxt.len > fscr_pkg::LEN_MAX) begin
      cfg_nxt.len = cfg_r.len;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= fscr_pkg::CFG_RESET_S;
    end else if (wr_done) begin
      cfg_r <= cfg_nxt;
    end
  end

  assign sync_read = cfg_r.sync_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_correct_en <= 1'b1;
    end else begin
      ecc_correct_en <= ~cfg_r.ecc_bypass;
    end
  end

  // Burst sequencer
  assign start_ok  = burst_start & cfg_r.sync_mode & (state_r == fscr_pkg::ST_IDLE);
  assign last_word = bounded_r & (word_cnt_r == mask_r);
  assign waddr_nxt = wrap_r ? ((waddr_r & ~mask_r) | ((waddr_r + 5'h01) & mask_r))
                            : (waddr_r + 5'h01);

  always_comb begin
    state_nxt = state_r;
    valid_nxt = 1'b0;
    unique case (state_r)
      fscr_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_nxt = fscr_pkg::ST_LAT;
        end
      end
      fscr_pkg::ST_LAT: begin
        if (burst_stop) begin
          state_nxt = fscr_pkg::ST_IDLE;
        end else if (lat_cnt_r == 3'h1) begin
          state_nxt = fscr_pkg::ST_DATA;
          valid_nxt = 1'b1;
        end
      end
      fscr_pkg::ST_DATA: begin
        if (burst_stop | last_word) begin
          state_nxt = fscr_pkg::ST_IDLE;
        end else begin
          valid_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = fscr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= fscr_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latency counted from the start edge to the first data cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_cnt_r <= 3'h0;
    end else if (start_ok) begin
      lat_cnt_r <= cfg_r.lat - 3'h1;
    end else if (state_r == fscr_pkg::ST_LAT) begin
      lat_cnt_r <= lat_cnt_r - 3'h1;
    end
  end

  // Burst shape captured at start so later writes cannot tear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r    <= 5'h1F;
      wrap_r    <= 1'b0;
      bounded_r <= 1'b0;
    end else if (start_ok) begin
      mask_r    <= fscr_pkg::len_mask(cfg_r.len);
      wrap_r    <= burst_wrap & (cfg_r.len != fscr_pkg::LEN_CONT);
      bounded_r <= (cfg_r.len != fscr_pkg::LEN_CONT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waddr_r    <= 5'h00;
      word_cnt_r <= 5'h00;
    end else if (start_ok) begin
      waddr_r    <= burst_col;
      word_cnt_r <= 5'h00;
    end else if ((state_r == fscr_pkg::ST_DATA) & valid_nxt) begin
      waddr_r    <= waddr_nxt;
      word_cnt_r <= word_cnt_r + 5'h01;
    end
  end

  assign data_valid = (state_r == fscr_pkg::ST_DATA);
  assign word_addr  = waddr_r;
  assign burst_busy = (state_r != fscr_pkg::ST_IDLE);

  // Ready leads data by one clock or coincides with it
  assign ready_level = cfg_r.rdy_conf ? data_valid : valid_nxt;

  fscr_pin_drv u_pin_drv (
    .out_en      (cfg_r.out_en),
    .rdy_pol     (cfg_r.rdy_pol),
    .irq_pol     (cfg_r.irq_pol),
    .ready_level (ready_level),
    .irq_ready   (irq_ready),
    .rdy_o       (rdy_o),
    .rdy_oe      (rdy_oe),
    .irq_o       (irq_o),
    .irq_oe      (irq_oe)
  );

  // Checks
  a_reset_value: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> fscr_pkg::to_word(cfg_r) == 16'h40C0)
    else $error("register not at reset value after reset");

  a_low_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata_r[3:0] == 4'h0 && prdata_r[31:16] == 16'h0000)
    else $error("read-only or reserved bits read nonzero");

  a_pins_undriven: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_r.out_en |-> !rdy_oe && !irq_oe)
    else $error("pin driven while output enable clear");

  a_oe_clear_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && pstrb[0] && !pwdata[5] |=> !cfg_r.out_en && !rdy_oe)
    else $error("output enable not cleared by write");

  a_irq_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq_oe |-> irq_o == (cfg_r.irq_pol ? irq_ready : !irq_ready))
    else $error("interrupt pin level wrong");

  a_rdy_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
    rdy_oe && data_valid && cfg_r.rdy_conf |-> rdy_o == cfg_r.rdy_pol)
    else $error("ready pin polarity wrong");

  a_rdy_early: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_r.rdy_conf && ready_level |=> data_valid)
    else $error("early ready not followed by data");

  a_async_no_burst: assert property (@(posedge pclk) disable iff (!presetn)
    burst_start && !cfg_r.sync_mode && !burst_busy |=> !burst_busy)
    else $error("burst started in asynchronous mode");

  a_latency_four: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok && cfg_r.lat == 3'h4 ##1 (!burst_stop && !data_valid) [*3] |=> data_valid)
    else $error("first data not four cycles after start");

  a_len_four_end: assert property (@(posedge pclk) disable iff (!presetn)
    data_valid && bounded_r && mask_r == 5'h03 && word_cnt_r == 5'h03 |=> !data_valid)
    else $error("four-word burst did not end");

  a_wrap_block: assert property (@(posedge pclk) disable iff (!presetn)
    data_valid && valid_nxt && wrap_r |=> (waddr_r & ~mask_r) == $past(waddr_r & ~mask_r))
    else $error("wrap burst left its block");

  a_ecc_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && pstrb[1] |=> ##1 ecc_correct_en == !$past(pwdata[8], 2))
    else $error("correction enable does not follow bit 8");

  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && pstrb[1] |=> sync_read == $past(pwdata[15]))
    else $error("read mode bit not taken from write");

  a_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok |=> burst_busy)
    else $error("accepted start did not begin a burst");

  a_lat_code_kept: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && pstrb[1] && (pwdata[14:12] < fscr_pkg::LAT_MIN)
      |=> cfg_r.lat == $past(cfg_r.lat))
    else $error("unsupported latency code changed the field");

  a_len_code_kept: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && pstrb[1] && (pwdata[11:9] > fscr_pkg::LEN_MAX)
      |=> cfg_r.len == $past(cfg_r.len))
    else $error("reserved length code changed the field");

  a_stop_ends_burst: assert property (@(posedge pclk) disable iff (!presetn)
    data_valid && burst_stop |=> !data_valid)
    else $error("burst went on after stop");

  a_oe_set_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && pstrb[0] && pwdata[5] |=> rdy_oe && irq_oe)
    else $error("pins not driven after output enable write");

  a_rdy_with_data: assert property (@(posedge pclk) disable iff (!presetn)
    rdy_oe && cfg_r.rdy_conf && !data_valid |-> rdy_o == !cfg_r.rdy_pol)
    else $error("ready shown without data");

  a_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !hit |=> cfg_r == $past(cfg_r))
    else $error("unmapped write changed the register");

  c_burst_done: cover property (@(posedge pclk) disable iff (!presetn)
    data_valid && last_word);
  c_wrap_done: cover property (@(posedge pclk) disable iff (!presetn)
    data_valid && wrap_r && last_word);
  c_burst_stop: cover property (@(posedge pclk) disable iff (!presetn)
    data_valid && burst_stop);
  c_pins_on: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(rdy_oe));
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);

endmodule

`default_nettype wire

// file: design/fscr_pkg.sv
// Constants, field layout and types of the system configuration register.
// Assumes a single 100 MHz clock domain and an APB slave holding the register.
`default_nettype none

package fscr_pkg;

  localparam int unsigned ADDR_W     = 20;
  localparam int unsigned WADDR_W    = 5;
  localparam logic [15:0] CFG_INDEX  = 16'hF221;
  localparam logic [19:0] CFG_ADDR   = {2'b00, CFG_INDEX, 2'b00};
  localparam logic [15:0] CFG_RESET  = 16'h40C0;

  localparam int unsigned BIT_MODE   = 15;
  localparam int unsigned LAT_LSB    = 12;
  localparam int unsigned LEN_LSB    = 9;
  localparam int unsigned BIT_ECC    = 8;
  localparam int unsigned BIT_RPOL   = 7;
  localparam int unsigned BIT_IPOL   = 6;
  localparam int unsigned BIT_OE     = 5;
  localparam int unsigned BIT_RCONF  = 4;

  localparam logic [2:0]  LAT_MIN    = 3'h3;
  localparam logic [2:0]  LEN_CONT   = 3'h0;
  localparam logic [2:0]  LEN_MAX    = 3'h4;

  typedef struct packed {
    logic       sync_mode;
    logic [2:0] lat;
    logic [2:0] len;
    logic       ecc_bypass;
    logic       rdy_pol;
    logic       irq_pol;
    logic       out_en;
    logic       rdy_conf;
  } fscr_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT  = 2'b01,
    ST_DATA = 2'b10
  } fscr_state_t;

  function automatic fscr_cfg_t from_word(input logic [15:0] w);
    fscr_cfg_t c;
    c.sync_mode  = w[BIT_MODE];
    c.lat        = w[LAT_LSB+:3];
    c.len        = w[LEN_LSB+:3];
    c.ecc_bypass = w[BIT_ECC];
    c.rdy_pol    = w[BIT_RPOL];
    c.irq_pol    = w[BIT_IPOL];
    c.out_en     = w[BIT_OE];
    c.rdy_conf   = w[BIT_RCONF];
    return c;
  endfunction

  // Bits 3:0 always read zero
  function automatic logic [15:0] to_word(input fscr_cfg_t c);
    return {c.sync_mode, c.lat, c.len, c.ecc_bypass, c.rdy_pol, c.irq_pol,
            c.out_en, c.rdy_conf, 4'h0};
  endfunction

  // Mask of the word address bits that advance within one burst
  function automatic logic [4:0] len_mask(input logic [2:0] code);
    logic [4:0] m;
    m = 5'h1F;
    unique case (code)
      3'h1:    m = 5'h03;
      3'h2:    m = 5'h07;
      3'h3:    m = 5'h0F;
      default: m = 5'h1F;
    endcase
    return m;
  endfunction

  localparam fscr_cfg_t CFG_RESET_S = from_word(CFG_RESET);

endpackage

`default_nettype wire

// file: design/fscr_pin_drv.sv
// Polarity and output-enable stage for the ready and interrupt pins.
// Inputs pass through unregistered; the pad or bench resolves the wire from the enables.
`default_nettype none

module fscr_pin_drv (
  input  wire logic out_en,
  input  wire logic rdy_pol,
  input  wire logic irq_pol,
  input  wire logic ready_level,
  input  wire logic irq_ready,
  output logic      rdy_o,
  output logic      rdy_oe,
  output logic      irq_o,
  output logic      irq_oe
);

  // Undriven pins also hold output low
  assign rdy_oe = out_en;
  assign irq_oe = out_en;
  assign rdy_o  = out_en & (rdy_pol ? ready_level : ~ready_level);
  assign irq_o  = out_en & (irq_pol ? irq_ready : ~irq_ready);

endmodule

`default_nettype wire

// file: verif/fscr_host.sv
// Host APB master model that reaches the configuration register.
// Assumes the bench calls xfer; each transfer starts at the next rising edge.
`default_nettype none

module fscr_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [19:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 20'h0_0000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
  end

  // Request held until pready is seen high at an edge, for at most 64 edges
  task automatic xfer(input logic w, input logic [19:0] a, input logic [15:0] d,
                      output logic [31:0] rd, output logic er, output logic hung);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    pstrb   <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd   = prdata;
    er   = pslverr;
    hung = (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data shows no stale value
    pwdata  <= ~{16'h0000, d};
  endtask
endmodule

`default_nettype wire

// file: verif/fscr_top_tb.sv
// Self-checking bench for the configuration register and its burst sequencer.
// Assumes the host model drives APB; bench drives burst and interrupt inputs.
`default_nettype none

module fscr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] A = fscr_pkg::CFG_ADDR;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        burst_start, burst_wrap, burst_stop, data_valid, burst_busy;
  logic [4:0]  burst_col, word_addr;
  logic        sync_read, ecc_correct_en, irq_ready, rdy_o, rdy_oe, irq_o, irq_oe;
  int          errors, samples_checked;

  fscr_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                  .pready, .prdata, .pslverr);
  fscr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                .pready, .prdata, .pslverr, .burst_start, .burst_wrap, .burst_col,
                .burst_stop, .data_valid, .word_addr, .burst_busy, .sync_read,
                .ecc_correct_en, .irq_ready, .rdy_o, .rdy_oe, .irq_o, .irq_oe);

  always #5 pclk = ~pclk;

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d,
                     input logic [15:0] ex, input logic ee);
    logic [31:0] rd;
    logic        er, hung;
    host.xfer(w, a, d, rd, er, hung);
    if (hung) begin
      errors++;
      $display("[ERR] pready expected 1 seen 0");
      summarize();
    end
    chk("pslverr", 32'(ee), 32'(er));
    if (!w) begin
      chk("prdata", {16'h0000, ex}, rd);
    end
  endtask

  task automatic pins(input logic ir, input logic [3:0] exp);
    @(posedge pclk);
    irq_ready <= ir;
    repeat (2) @(posedge pclk);
    #1;
    chk("oe/pin", 32'(exp), 32'({rdy_oe, rdy_o, irq_oe, irq_o}));
  endtask

  task automatic burst(input logic [2:0] lat, input logic [2:0] len, input logic cf,
                       input logic wr, input logic [4:0] col, input int stop_at);
    int         nv, n;
    logic [4:0] ea, m;
    acc(1'b1, A, {1'b1, lat, len, 1'b0, 1'b1, 1'b0, 1'b1, cf, 4'h0}, 16'h0000, 1'b0);
    n  = (len == 3'h0) ? stop_at : (2 << len);
    m  = (len == 3'h0) ? 5'h1F : 5'(n - 1);
    ea = col;
    nv = 0;
    @(posedge pclk);
    burst_start <= 1'b1;
    burst_wrap  <= wr;
    burst_col   <= col;
    @(posedge pclk);
    burst_start <= 1'b0;
    for (int k = 1; k < 60; k++) begin
      @(posedge pclk);
      // Values seen here are sampled by the DUT at edge k + 1
      burst_stop <= (stop_at > 0 && k == int'(lat) + stop_at - 2);
      #1;
      if (k == int'(lat) - 2) begin
        chk("early ready", 32'(!cf), 32'(rdy_o));
      end
      if (data_valid === 1'b1) begin
        if (nv == 0) begin
          chk("latency", 32'(lat) - 32'h0000_0001, 32'(k));
        end
        chk("word_addr", 32'(ea), 32'(word_addr));
        ea = (wr && len != 3'h0) ? ((ea & ~m) | ((ea + 5'h01) & m)) : ea + 5'h01;
        nv++;
      end
    end
    chk("burst words", 32'(n), 32'(nv));
    $display("test burst lat %0d len %0d done", lat, len);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    $display("[ERR] run time expected end seen limit");
    summarize();
  end

  initial begin
    presetn = 1'b0;
    burst_start = 1'b0;
    burst_wrap = 1'b0;
    burst_col = 5'h00;
    burst_stop = 1'b0;
    irq_ready = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, A, 16'h0000, 16'h40C0, 1'b0);
    chk("sync_read", 32'h0, 32'(sync_read));
    chk("ecc_en", 32'h1, 32'(ecc_correct_en));
    chk("pin oe", 32'h0, 32'({rdy_oe, irq_oe}));
    $display("test reset done");
    acc(1'b1, A, 16'hFFFF, 16'h0000, 1'b0);
    acc(1'b0, A, 16'h0000, 16'hF1F0, 1'b0);
    chk("sync_read", 32'h1, 32'(sync_read));
    chk("ecc_en", 32'h0, 32'(ecc_correct_en));
    acc(1'b1, A, 16'h3A0F, 16'h0000, 1'b0);
    acc(1'b0, A, 16'h0000, 16'h3000, 1'b0);
    acc(1'b1, A, 16'h1000, 16'h0000, 1'b0);
    acc(1'b0, A, 16'h0000, 16'h3000, 1'b0);
    chk("ecc_en", 32'h1, 32'(ecc_correct_en));
    acc(1'b1, A + 20'h0_0004, 16'hFFFF, 16'h0000, 1'b1);
    acc(1'b0, A + 20'h0_0004, 16'h0000, 16'h0000, 1'b1);
    acc(1'b0, A, 16'h0000, 16'h3000, 1'b0);
    $display("test fields done");
    acc(1'b1, A, 16'h40E0, 16'h0000, 1'b0);
    pins(1'b1, 4'b1011);
    pins(1'b0, 4'b1010);
    acc(1'b1, A, 16'h4020, 16'h0000, 1'b0);
    pins(1'b1, 4'b1110);
    pins(1'b0, 4'b1111);
    acc(1'b1, A, 16'h40C0, 16'h0000, 1'b0);
    pins(1'b1, 4'b0000);
    $display("test pins done");
    burst(3'h3, 3'h1, 1'b0, 1'b1, 5'h06, 0);
    burst(3'h7, 3'h2, 1'b1, 1'b0, 5'h1E, 0);
    burst(3'h4, 3'h3, 1'b0, 1'b1, 5'h0D, 0);
    burst(3'h5, 3'h4, 1'b1, 1'b1, 5'h11, 0);
    burst(3'h6, 3'h0, 1'b0, 1'b1, 5'h1F, 3);
    acc(1'b1, A, 16'h40C0, 16'h0000, 1'b0);
    @(posedge pclk);
    burst_start <= 1'b1;
    repeat (2) @(posedge pclk);
    burst_start <= 1'b0;
    #1;
    chk("busy in async", 32'h0, 32'(burst_busy));
    acc(1'b1, A, 16'h40E0, 16'h0000, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk("oe in reset", 32'h0, 32'({rdy_oe, irq_oe}));
    @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, A, 16'h0000, 16'h40C0, 1'b0);
    $display("test async and reset done");
    summarize();
  end
endmodule

`default_nettype wire
